//--- src/cfg_if.sv
// Purpose: decoded switch configuration passed inside the gateway
// Assumes: driven only by the switch synchroniser
// Notes: node numbers already carry the plus one
interface cfg_if;
  import gw_pkg::*;
  logic [NODE_W-1:0] host_node;
  logic [NODE_W-1:0] own_node;
  logic [SWV_W-1:0] own_val;
  logic [LINK_N-1:0] links_en;
  logic global_ctl;
  logic comm_loss_fault_switch;
  modport src (output host_node, own_node, own_val, links_en, global_ctl,
    comm_loss_fault_switch);
  modport dst (input host_node, own_node, own_val, links_en, global_ctl,
    comm_loss_fault_switch);
endinterface

//--- src/drive_gateway.sv
// Purpose: global data exchange between a fieldbus host and a motor drive
// Assumes: network receive and transmit logic run on clk_i
// Notes: switch banks are pins and are synchronised first
//
// What this block does
// - first bank positions 1-6 pick the host node whose global data controls.
// - first bank positions 7-8 pick enabled datalinks; both on enables A-D.
// - second bank positions 1-6 set the gateway's own node address.
// - second bank position 7 on takes control and reference from host global data.
// - second bank position 8 on faults the drive when communication is lost.
// - own node picks its word pair; node 6 uses offsets 10 and 11.
// - drive status word goes out first, at offset zero.
// - offset 1 feedback, offsets 2-9 datalinks A1 through D2.
// - host bit 1 is the msb; control and status word bits are renumbered to drive order.
// - control bit 0 high asks the drive to stop.
// - writes to words of a disabled datalink are dropped.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
module drive_gateway
  import gw_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration switch pins
  input wire logic [SW_W-1:0] host_select_switch_bank_i,
  input wire logic [SW_W-1:0] local_config_switch_bank_i,
  // global data received from the network, index 15 carries host bit 1
  input wire logic gd_valid_i,
  input wire logic [NODE_W-1:0] gd_src_node_i,
  input wire logic [OFS_W-1:0] gd_offset_i,
  input wire logic [WORD_W-1:0] gd_word_i,
  input wire logic gd_last_i,
  input wire logic comm_ok_i,
  // host writes of datalink input words
  input wire logic hw_valid_i,
  input wire logic [7:0] hw_index_i,
  input wire logic [WORD_W-1:0] hw_word_i,
  // global output stream
  input wire logic tx_start_i,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [TXI_W-1:0] tx_index_o,
  output logic [WORD_W-1:0] tx_word_o,
  output logic tx_last_o,
  // drive side
  output logic [WORD_W-1:0] drive_ctrl_o,
  output logic [WORD_W-1:0] drive_ref_o,
  output dl_block_t drive_dl_in_o,
  output logic drive_update_o,
  output logic drive_fault_o,
  input wire logic [WORD_W-1:0] drive_status_i,
  input wire logic [WORD_W-1:0] drive_feedback_i,
  input wire dl_block_t drive_dl_out_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  cfg_if cfg ();

  switch_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .host_bank_i(host_select_switch_bank_i),
    .local_bank_i(local_config_switch_bank_i),
    .cfg(cfg)
  );

  // registers
  logic [WORD_W-1:0] ctl_buf_q;
  logic [WORD_W-1:0] ref_buf_q;
  logic [1:0] seen_q;
  logic [WORD_W-1:0] ctrl_word_q;
  logic [WORD_W-1:0] ctrl_out_q;
  logic [WORD_W-1:0] ref_q;
  dl_block_t dl_in_q;
  logic update_q;
  logic fault_q;
  logic [31:0] ctrl_reg_q;
  logic [31:0] frames_q;
  logic [31:0] rdata_q;
  logic ack_q;

  // frame filtering and word selection
  wire logic [OFS_W-1:0] ctl_ofs = {cfg.own_val, 1'b0};
  wire logic [OFS_W-1:0] ref_ofs = {cfg.own_val, 1'b1};
  wire logic from_host = gd_valid_i && cfg.global_ctl
    && (gd_src_node_i == cfg.host_node)
    && (gd_src_node_i != cfg.own_node);
  wire logic hit_ctl = from_host && (gd_offset_i == ctl_ofs);
  wire logic hit_ref = from_host && (gd_offset_i == ref_ofs);
  wire logic [1:0] seen_d = seen_q | {hit_ref, hit_ctl};
  wire logic [WORD_W-1:0] ctl_buf_d = hit_ctl ? bit_flip(gd_word_i) : ctl_buf_q;
  wire logic [WORD_W-1:0] ref_buf_d = hit_ref ? gd_word_i : ref_buf_q;
  wire logic frame_end = from_host && gd_last_i;
  wire logic commit = frame_end && (&seen_d);

  // communication loss
  wire logic comm_lost = !comm_ok_i;
  wire logic fault_d = cfg.comm_loss_fault_switch && comm_lost;
  wire logic [WORD_W-1:0] ctrl_word_d = commit ? ctl_buf_d : ctrl_word_q;
  wire logic [WORD_W-1:0] ctrl_out_d = fault_d ? (ctrl_word_d | STOP_MASK)
    : ctrl_word_d;

  // datalink input writes from the host
  wire logic [7:0] hw_slot = hw_index_i - DL_IN_FIRST;
  wire logic hw_in_range = (hw_index_i >= DL_IN_FIRST) && (hw_index_i <= DL_IN_LAST);
  wire logic hw_link_on = cfg.links_en[hw_slot[2:1]];
  wire logic hw_take = hw_valid_i && hw_in_range && hw_link_on;

  // global output block
  tx_block_t tx_block;
  always_comb begin
    tx_block = '0;
    tx_block[TX_STATUS_OFS] = bit_flip(drive_status_i);
    tx_block[TX_FEEDBACK_OFS] = drive_feedback_i;
    for (int k = 0; k < DL_WORDS; k++) begin
      tx_block[int'(TX_DL_OFS) + k] = cfg.links_en[k/2] ? drive_dl_out_i[k]
        : '0;
    end
  end

  wire logic tx_go = tx_start_i && ctrl_reg_q[CTRL_TX_EN_BIT];

  global_tx u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tx_go),
    .block_i(tx_block),
    .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i),
    .tx_index_o(tx_index_o),
    .tx_word_o(tx_word_o),
    .tx_last_o(tx_last_o),
    .busy_o()
  );

  // host data path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_buf_q <= '0;
      ref_buf_q <= '0;
      seen_q <= 2'h0;
      ctrl_word_q <= '0;
      ctrl_out_q <= '0;
      ref_q <= '0;
      update_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      ctl_buf_q <= ctl_buf_d;
      ref_buf_q <= ref_buf_d;
      seen_q <= frame_end ? 2'h0 : seen_d;
      ctrl_word_q <= ctrl_word_d;
      ctrl_out_q <= ctrl_out_d;
      ref_q <= commit ? ref_buf_d : ref_q;
      update_q <= commit;
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dl_in_q <= '0;
    end else if (hw_take) begin
      dl_in_q[hw_slot[2:0]] <= hw_word_i;
    end
  end

  // wishbone register file
  wire logic wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic wb_wr = wb_req && wb_we_i;
  wire logic wr_ctrl = wb_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
  wire logic wr_frames = wb_wr && (wb_adr_i == REG_FRAMES);

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[ST_HOST_LSB +: NODE_W] = cfg.host_node;
    status_word[ST_OWN_LSB +: NODE_W] = cfg.own_node;
    status_word[ST_LINK_LSB +: LINK_N] = cfg.links_en;
    status_word[ST_GCTL_BIT] = cfg.global_ctl;
    status_word[ST_CFE_BIT] = cfg.comm_loss_fault_switch;
    status_word[ST_LOST_BIT] = comm_lost;
    status_word[ST_FAULT_BIT] = fault_q;
  end

  logic [31:0] rd_mux;
  always_comb begin
    unique case (wb_adr_i)
      REG_CTRL: rd_mux = ctrl_reg_q;
      REG_STATUS: rd_mux = status_word;
      REG_FRAMES: rd_mux = frames_q;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg_q <= CTRL_RST;
      frames_q <= '0;
      rdata_q <= '0;
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
      rdata_q <= wb_req ? rd_mux : '0;
      if (wr_ctrl) begin
        ctrl_reg_q <= wb_dat_i & CTRL_MASK;
      end
      if (commit) begin
        frames_q <= frames_q + 32'h1;
      end else if (wr_frames) begin
        frames_q <= '0;
      end
    end
  end

  assign drive_ctrl_o = ctrl_out_q;
  assign drive_ref_o = ref_q;
  assign drive_dl_in_o = dl_in_q;
  assign drive_update_o = update_q;
  assign drive_fault_o = fault_q;
  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;

endmodule // drive_gateway

//--- src/global_tx.sv
// Purpose: send the gateway's global output block word by word
// Assumes: the network side takes a word when valid and ready are high
// Notes: the block is snapshot at start so words stay coherent
module global_tx
  import gw_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // block to send
  input wire logic start_i,
  input wire tx_block_t block_i,
  // word stream
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [TXI_W-1:0] tx_index_o,
  output logic [WORD_W-1:0] tx_word_o,
  output logic tx_last_o,
  output logic busy_o
);
  tx_state_t state_q;
  tx_block_t snap_q;
  logic [TXI_W-1:0] idx_q;
  logic [WORD_W-1:0] word_q;
  logic valid_q;
  logic last_q;
  wire logic take = (state_q == TX_SEND) && tx_ready_i;
  wire logic at_end = (idx_q == TX_LAST_OFS);
  wire logic [TXI_W-1:0] idx_nxt = idx_q + 4'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= TX_IDLE;
      snap_q <= '0;
      idx_q <= TX_STATUS_OFS;
      word_q <= '0;
      valid_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      unique case (state_q)
        TX_IDLE: begin
          if (start_i) begin
            snap_q <= block_i;
            idx_q <= TX_STATUS_OFS;
            word_q <= block_i[TX_STATUS_OFS];
            valid_q <= 1'b1;
            last_q <= 1'b0;
            state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (take && at_end) begin
            valid_q <= 1'b0;
            last_q <= 1'b0;
            state_q <= TX_IDLE;
          end else if (take) begin
            idx_q <= idx_nxt;
            word_q <= snap_q[idx_nxt];
            last_q <= (idx_nxt == TX_LAST_OFS);
          end
        end
        default: state_q <= TX_IDLE;
      endcase
    end
  end

  // stream outputs straight from flops; busy_o decoded from state_q
  assign tx_valid_o = valid_q;
  assign tx_index_o = idx_q;
  assign tx_word_o = word_q;
  assign tx_last_o = last_q;
  assign busy_o = (state_q == TX_SEND);
endmodule // global_tx

//--- src/gw_pkg.sv
// Purpose: shared constants, types and helpers of the drive gateway
// Assumes: 16-bit network words, 32-bit classic wishbone register bus
// Notes: node numbers are switch value plus one
package gw_pkg;

  localparam int WORD_W = 16;
  localparam int NODE_W = 7;
  localparam int SWV_W = 6;
  localparam int SW_W = 8;
  localparam int OFS_W = 7;
  localparam int LINK_N = 4;
  localparam int DL_WORDS = 8;
  localparam int TX_WORDS = 10;
  localparam int TXI_W = 4;

  // switch bank layout: position n sits at bit n-1
  localparam int SW_NODE_LSB = 0;
  localparam int SW_NODE_MSB = 5;
  localparam int SW_POS7 = 6;
  localparam int SW_POS8 = 7;
  localparam logic [NODE_W-1:0] NODE_ONE = 7'h01;

  // datalink enable encodings of positions 8 and 7
  localparam logic [1:0] LINKS_NONE = 2'h0;
  localparam logic [1:0] LINKS_A = 2'h1;
  localparam logic [1:0] LINKS_AB = 2'h2;
  localparam logic [1:0] LINKS_ALL = 2'h3;

  // global output layout of the gateway's broadcast
  localparam logic [TXI_W-1:0] TX_STATUS_OFS = 4'h0;
  localparam logic [TXI_W-1:0] TX_FEEDBACK_OFS = 4'h1;
  localparam logic [TXI_W-1:0] TX_DL_OFS = 4'h2;
  localparam logic [TXI_W-1:0] TX_LAST_OFS = 4'h9;

  // host write index of datalink input word a1
  localparam logic [7:0] DL_IN_FIRST = 8'h03;
  localparam logic [7:0] DL_IN_LAST = 8'h0a;

  // drive control word
  localparam int CTRL_STOP_BIT = 0;
  localparam logic [WORD_W-1:0] STOP_MASK = 16'h0001;

  // wishbone register map, byte addresses
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] REG_FRAMES = 4'h8;
  localparam int CTRL_TX_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam int ST_HOST_LSB = 0;
  localparam int ST_OWN_LSB = 8;
  localparam int ST_LINK_LSB = 16;
  localparam int ST_GCTL_BIT = 20;
  localparam int ST_CFE_BIT = 21;
  localparam int ST_LOST_BIT = 22;
  localparam int ST_FAULT_BIT = 23;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } tx_state_t;

  typedef logic [TX_WORDS-1:0][WORD_W-1:0] tx_block_t;
  typedef logic [DL_WORDS-1:0][WORD_W-1:0] dl_block_t;

  // host numbers bits from the top, the drive from bit 0
  function automatic logic [WORD_W-1:0] bit_flip(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++) begin
      r[i] = w[WORD_W-1-i];
    end
    return r;
  endfunction

  function automatic logic [LINK_N-1:0] links_from_sw(input logic [1:0] s);
    logic [LINK_N-1:0] r;
    r = 4'h0;
    unique case (s)
      LINKS_NONE: r = 4'h0;
      LINKS_A: r = 4'h1;
      LINKS_AB: r = 4'h3;
      LINKS_ALL: r = 4'hf;
    endcase
    return r;
  endfunction

endpackage

//--- src/switch_sync.sv
// Purpose: synchronise both switch banks and decode them
// Assumes: switches are asynchronous pins
// Notes: decode reads only the second flop
module switch_sync
  import gw_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // switch pins
  input wire logic [SW_W-1:0] host_bank_i,
  input wire logic [SW_W-1:0] local_bank_i,
  // decoded configuration
  cfg_if.src cfg
);
  logic [SW_W-1:0] host_m_q;
  logic [SW_W-1:0] host_s_q;
  logic [SW_W-1:0] local_m_q;
  logic [SW_W-1:0] local_s_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_m_q <= '0;
      host_s_q <= '0;
      local_m_q <= '0;
      local_s_q <= '0;
    end else begin
      host_m_q <= host_bank_i;
      host_s_q <= host_m_q;
      local_m_q <= local_bank_i;
      local_s_q <= local_m_q;
    end
  end

  assign cfg.host_node = {1'b0, host_s_q[SW_NODE_MSB:SW_NODE_LSB]} + NODE_ONE;
  assign cfg.own_val = local_s_q[SW_NODE_MSB:SW_NODE_LSB];
  assign cfg.own_node = {1'b0, local_s_q[SW_NODE_MSB:SW_NODE_LSB]} + NODE_ONE;
  assign cfg.links_en = links_from_sw({host_s_q[SW_POS8], host_s_q[SW_POS7]});
  assign cfg.global_ctl = local_s_q[SW_POS7];
  assign cfg.comm_loss_fault_switch = local_s_q[SW_POS8];
endmodule // switch_sync

//--- tb/drive_gateway_global_data_map_bench.sv
// Purpose: self-checking bench of the drive gateway
// Assumes: host model sends frames, bench plays drive and software
// Notes: row table of frames first, then directed cases
module drive_gateway_global_data_map_bench
  import gw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] hs;
    logic [7:0] ls;
    logic [NODE_W-1:0] src;
    logic [WORD_W-1:0] ctl;
    logic [WORD_W-1:0] rf;
    logic upd;
  } row_t;
  row_t rows [6] = '{
    '{8'hc6, 8'h45, 7'h07, 16'h4000, 16'hc3c3, 1'b1},
    '{8'hc6, 8'h45, 7'h07, 16'h8000, 16'h8001, 1'b1},
    '{8'hc6, 8'h45, 7'h08, 16'h4000, 16'h0ff0, 1'b0},
    '{8'hc6, 8'h05, 7'h07, 16'h4000, 16'h0ff0, 1'b0},
    '{8'h3f, 8'h40, 7'h40, 16'h0001, 16'h0ff0, 1'b1},
    '{8'h06, 8'h7e, 7'h07, 16'h00f0, 16'h7ffe, 1'b1}};
  logic clk_i, seen, gd_valid, gd_last, tx_valid, tx_last, upd, fault, wb_ack, tx_ready;
  logic rst_i = 1'b1;
  logic comm_ok = 1'b1;
  logic hw_valid = 1'b0, tx_start = 1'b0, stall = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
  logic [7:0] host_sw = 8'hc6, local_sw = 8'h45, hw_index = 8'h00;
  logic [15:0] hw_word = 16'h0000, status = 16'h8003, fbk = 16'h1234;
  logic [15:0] ectl = 16'h0000, erf = 16'h0000, tx_exp, gd_word, tx_word, ctrl, refw;
  logic [31:0] wb_dat = 32'h0, wb_q, rd;
  logic [NODE_W-1:0] gd_src;
  logic [OFS_W-1:0] gd_ofs;
  logic [TXI_W-1:0] tx_index;
  dl_block_t dl_in, dl_out;
  logic [15:0] got_tx [10];
  int n;
  int n_errors = 0;
  int samples_checked = 0;

  plc_host_model i_plc_host_model (.clk_i(clk_i), .gd_valid_o(gd_valid), .gd_src_node_o(gd_src),
    .gd_offset_o(gd_ofs), .gd_word_o(gd_word), .gd_last_o(gd_last), .stall_i(stall),
    .tx_ready_o(tx_ready));
  drive_gateway i_drive_gateway (.clk_i(clk_i), .rst_i(rst_i),
    .host_select_switch_bank_i(host_sw), .local_config_switch_bank_i(local_sw),
    .gd_valid_i(gd_valid), .gd_src_node_i(gd_src), .gd_offset_i(gd_ofs), .gd_word_i(gd_word),
    .gd_last_i(gd_last), .comm_ok_i(comm_ok), .hw_valid_i(hw_valid), .hw_index_i(hw_index),
    .hw_word_i(hw_word), .tx_start_i(tx_start), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .tx_index_o(tx_index), .tx_word_o(tx_word), .tx_last_o(tx_last), .drive_ctrl_o(ctrl),
    .drive_ref_o(refw), .drive_dl_in_o(dl_in), .drive_update_o(upd), .drive_fault_o(fault),
    .drive_status_i(status), .drive_feedback_i(fbk), .drive_dl_out_i(dl_out),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (tx_valid && tx_ready) got_tx[tx_index] <= tx_word;

  function automatic logic [15:0] rev16(input logic [15:0] w);
    for (int k = 0; k < 16; k++) rev16[k] = w[15-k];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic give_up();
    n_errors++;
    print_verdict();
  endtask
  task automatic wb_io(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) give_up();
    rd = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
  endtask
  task automatic hw_put(input logic [7:0] idx, input logic [15:0] w);
    hw_valid <= 1'b1;
    hw_index <= idx;
    hw_word <= w;
    @(posedge clk_i);
    hw_valid <= 1'b0;
    @(posedge clk_i);
  endtask

  initial begin
    for (int k = 0; k < 8; k++) dl_out[k] = {12'h0a0, 4'(k)};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk_i);
      host_sw <= rows[i].hs;
      local_sw <= rows[i].ls;
      repeat (4) @(posedge clk_i);
      i_plc_host_model.send_frame(rows[i].src, {rows[i].ls[5:0], 1'b0}, rows[i].ctl, rows[i].rf);
      seen = 1'b0;
      repeat (3) begin
        @(posedge clk_i);
        seen = seen | upd;
      end
      if (rows[i].upd) begin
        ectl = rev16(rows[i].ctl);
        erf = rows[i].rf;
      end
      chk(seen, rows[i].upd);
      chk(ctrl, ectl);
      chk(refw, erf);
    end
    // only link a enabled: writes to link b are dropped
    host_sw <= 8'h46;
    repeat (4) @(posedge clk_i);
    hw_put(8'h03, 16'h1111);
    chk(dl_in[0], 16'h1111);
    hw_put(8'h05, 16'h2222);
    chk(dl_in[2], 16'h0000);
    // broadcast with the network stalling every other cycle
    stall <= 1'b1;
    tx_start <= 1'b1;
    @(posedge clk_i);
    tx_start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(tx_valid && tx_ready && tx_last) && n < 60);
    if (tx_last !== 1'b1) give_up();
    @(posedge clk_i);
    stall <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      tx_exp = (k == 0) ? rev16(status) : (k == 1) ? fbk : 16'h0000;
      if (k == 2 || k == 3) tx_exp = dl_out[k-2];
      chk(got_tx[k], tx_exp);
    end
    // links a and b only: b2 lands, c1 dropped
    host_sw <= 8'h86;
    repeat (4) @(posedge clk_i);
    hw_put(8'h06, 16'h4444);
    chk(dl_in[3], 16'h4444);
    hw_put(8'h07, 16'h5555);
    chk(dl_in[4], 16'h0000);
    host_sw <= 8'hc6;
    repeat (4) @(posedge clk_i);
    hw_put(8'h0a, 16'h3333);
    chk(dl_in[7], 16'h3333);
    // link loss with the fault switch off, then on
    comm_ok <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(fault, 1'b0);
    comm_ok <= 1'b1;
    local_sw <= 8'hc5;
    repeat (4) @(posedge clk_i);
    wb_io(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h003f_0607);
    wb_io(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    // four rows commit a frame; a write clears the count
    wb_io(1'b0, REG_FRAMES, 32'h0);
    chk(rd, 32'h0000_0004);
    wb_io(1'b1, REG_FRAMES, 32'h0);
    wb_io(1'b0, REG_FRAMES, 32'h0);
    chk(rd, 32'h0);
    comm_ok <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({fault, ctrl[0]}, 2'h3);
    // broadcast disabled by software
    wb_io(1'b1, REG_CTRL, 32'h0);
    wb_io(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    tx_start <= 1'b1;
    @(posedge clk_i);
    tx_start <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(tx_valid, 1'b0);
    // second reset clears the drive side
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({ctrl, refw}, 32'h0);
    chk({upd, fault, tx_valid, wb_ack}, 4'h0);
    print_verdict();
  end
endmodule // drive_gateway_global_data_map_bench

//--- tb/drive_gateway_properties.sv
// Purpose: concurrent checks on the drive gateway top ports
// Assumes: one clock, synchronous active-high reset
// Notes: switch conditions wait out the two-flop synchroniser
module drive_gateway_checker
  import gw_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched inputs
  input wire logic [SW_W-1:0] host_select_switch_bank_i,
  input wire logic [SW_W-1:0] local_config_switch_bank_i,
  input wire logic gd_valid_i,
  input wire logic [NODE_W-1:0] gd_src_node_i,
  input wire logic gd_last_i,
  input wire logic comm_ok_i,
  input wire logic tx_ready_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  // watched outputs
  input wire logic tx_valid_o,
  input wire logic [TXI_W-1:0] tx_index_o,
  input wire logic tx_last_o,
  input wire logic [WORD_W-1:0] drive_ctrl_o,
  input wire logic [WORD_W-1:0] drive_ref_o,
  input wire logic drive_update_o,
  input wire logic drive_fault_o,
  input wire logic wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [NODE_W-1:0] host_node;
  assign host_node = {1'b0, host_select_switch_bank_i[SW_NODE_MSB:0]} + NODE_ONE;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence loss_s;
    (local_config_switch_bank_i[SW_POS8] && !comm_ok_i) [*4];
  endsequence
  sequence steady_s;
    ($stable(host_select_switch_bank_i) && $stable(local_config_switch_bank_i)) [*3];
  endsequence
  sequence take_s;
    tx_valid_o && tx_ready_i;
  endsequence
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  AST_FAULT_SET: assert property (
    loss_s |=> drive_fault_o && drive_ctrl_o[CTRL_STOP_BIT])
    else $error("no fault and stop after link loss");
  AST_FAULT_OFF: assert property (
    !local_config_switch_bank_i[SW_POS8] [*4] |=> !drive_fault_o)
    else $error("fault raised with loss switch off");
  AST_IGNORE_FRAME: assert property (
    steady_s ##0 (gd_valid_i && gd_last_i
    && (gd_src_node_i != host_node || !local_config_switch_bank_i[SW_POS7]))
    |=> !drive_update_o)
    else $error("update from a frame that must be ignored");
  AST_UPD_CAUSE: assert property (
    drive_update_o |-> $past(gd_valid_i) && $past(gd_last_i))
    else $error("update without a frame end");
  AST_REF_HOLD: assert property (!drive_update_o |-> $stable(drive_ref_o))
    else $error("reference changed without update");
  AST_TX_FIRST: assert property ($rose(tx_valid_o) |-> tx_index_o == TX_STATUS_OFS)
    else $error("broadcast does not begin at offset zero");
  AST_TX_STEP: assert property (
    take_s ##0 !tx_last_o |=> tx_valid_o && tx_index_o == $past(tx_index_o) + 4'h1)
    else $error("broadcast offset did not step");
  AST_TX_LAST: assert property (
    tx_valid_o |-> tx_last_o == (tx_index_o == TX_LAST_OFS))
    else $error("last flag not on offset nine");
  AST_TX_END: assert property (take_s ##0 tx_last_o |=> !tx_valid_o)
    else $error("broadcast ran past offset nine");
endmodule // drive_gateway_checker

bind drive_gateway drive_gateway_checker i_drive_gateway_checker (
  .clk_i(clk_i), .rst_i(rst_i), .host_select_switch_bank_i(host_select_switch_bank_i),
  .local_config_switch_bank_i(local_config_switch_bank_i), .gd_valid_i(gd_valid_i),
  .gd_src_node_i(gd_src_node_i), .gd_last_i(gd_last_i), .comm_ok_i(comm_ok_i),
  .tx_ready_i(tx_ready_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .tx_valid_o(tx_valid_o),
  .tx_index_o(tx_index_o), .tx_last_o(tx_last_o), .drive_ctrl_o(drive_ctrl_o),
  .drive_ref_o(drive_ref_o), .drive_update_o(drive_update_o), .drive_fault_o(drive_fault_o),
  .wb_ack_o(wb_ack_o));

//--- tb/plc_host_model.sv
// Purpose: fieldbus host model sending global data, taking the broadcast
// Assumes: outputs change just after rising edges of clk_i
// Notes: between frames the data lines show the inverse of their last value
module plc_host_model
  import gw_pkg::*;
(
  // clock
  input wire logic clk_i,
  // global data towards the gateway
  output logic gd_valid_o,
  output logic [NODE_W-1:0] gd_src_node_o,
  output logic [OFS_W-1:0] gd_offset_o,
  output logic [WORD_W-1:0] gd_word_o,
  output logic gd_last_o,
  // broadcast acceptance, stall toggles ready
  input wire logic stall_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    gd_valid_o = 1'b0;
    gd_src_node_o = 7'h00;
    gd_offset_o = 7'h00;
    gd_word_o = 16'h0000;
    gd_last_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  always @(posedge clk_i)
    tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
  // block runs from offset 0 up to the pair in use only
  task automatic send_frame(input logic [NODE_W-1:0] src, input logic [OFS_W-1:0] pair,
    input logic [WORD_W-1:0] ctl, input logic [WORD_W-1:0] rf);
    for (int o = 0; o <= int'(pair) + 1; o++) begin
      @(posedge clk_i);
      gd_valid_o <= 1'b1;
      gd_src_node_o <= src;
      gd_offset_o <= OFS_W'(o);
      gd_word_o <= (o == int'(pair)) ? ctl : (o > int'(pair)) ? rf : 16'h5a5a;
      gd_last_o <= (o > int'(pair));
    end
    @(posedge clk_i);
    gd_valid_o <= 1'b0;
    gd_last_o <= 1'b0;
    gd_src_node_o <= ~gd_src_node_o;
    gd_offset_o <= ~gd_offset_o;
    gd_word_o <= ~gd_word_o;
  endtask
endmodule // plc_host_model
